/* File: led_engine_defs.svh */
// Offsets, reset values and timing counts for the LED dimming and animation engine
`ifndef LED_ENGINE_DEFS_SVH
`define LED_ENGINE_DEFS_SVH

`define SYS_CLK_HZ 25000000
`define OSC_HZ 6000000
// Fractional divider: add INC, wrap at MOD, toggle on wrap, so the toggle rate is twice OSC_HZ
`define OSC_ACC_INC (2 * `OSC_HZ / 1000000)
`define OSC_ACC_MOD (`SYS_CLK_HZ / 1000000)
`define TICKS_PER_MS (`OSC_HZ / 1000)

`define PWM_FAST_HZ 24000
`define PWM_SLOW_HZ 12000
`define PWM_SLOW_DIV (`PWM_FAST_HZ / `PWM_SLOW_HZ)
`define PWM_SLOTS 256
`define PWM_HALF 9'h080

`define FULL_SCALE_LOW_UA 25500
`define FULL_SCALE_HIGH_UA 51000
`define CODE_FULL 255
`define CURRENT_LSB_UA 100

`define CUR_LEVEL_RST 8'h80
`define CUR_RANGE_RST 1'b0

`define REPEAT_NONE 2'h0
`define REPEAT_INFINITE 2'h3
`define NO_GROUP 2'h3
`define LAST_RAMP 2'h3
`define STEP_END 9'h100
`define STEP_ADD 32'h00000100

`define DUR_MS_0 0
`define DUR_MS_1 90
`define DUR_MS_2 180
`define DUR_MS_3 360
`define DUR_MS_4 540
`define DUR_MS_5 800
`define DUR_MS_6 1070
`define DUR_MS_7 1520
`define DUR_MS_8 2060
`define DUR_MS_9 2500
`define DUR_MS_A 3040
`define DUR_MS_B 4020
`define DUR_MS_C 5010
`define DUR_MS_D 5990
`define DUR_MS_E 7060
`define DUR_MS_F 8050

`endif

/* File: led_pkg.sv */
// Types shared by the LED dimming and animation engine
package led_pkg;

  typedef logic [7:0] level_t;
  typedef logic [3:0] dur_code_t;

  typedef enum logic [1:0] {
    ALIGN_FORWARD = 2'h0,
    ALIGN_MIDDLE = 2'h1,
    ALIGN_BACKWARD = 2'h2
  } align_t;

  typedef struct packed {
    logic [1:0] group_repeat_count;
    level_t [4:0] level;
    dur_code_t [3:0] dur;
  } group_cfg_t;

  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01,
    SEQ_HOLD1 = 5'h02,
    SEQ_RAMP = 5'h04,
    SEQ_HOLD2 = 5'h08,
    SEQ_DONE = 5'h10
  } seq_state_t;

  typedef struct packed {
    logic current_range;
    level_t current_level;
    logic [4:0] osc_acc;
    logic sync_osc;
    logic sync_meta;
    logic sync_sync;
    logic sync_prev;
    logic sync_oe_b;
    logic tick;
    seq_state_t seq;
    logic [1:0] grp;
    logic [1:0] rmp;
    logic [1:0] grp_plays;
    logic [1:0] pat_plays;
    logic [25:0] time_acc;
    logic [8:0] step;
    level_t anim_pwm;
    logic [8:0] sink_current;
    level_t duty;
    align_t align;
    logic exp_en;
    logic pwm_slow;
  } engine_state_t;

  typedef struct packed {
    logic [7:0] slot;
    logic div;
    logic on;
  } pwm_state_t;

endpackage

/* File: pwm_if.sv */
// Carrier between the engine core and its PWM waveform generator
`timescale 1ns/1ns
interface pwm_if;
  import led_pkg::*;
  logic tick;
  level_t duty;
  align_t align;
  logic exp_en;
  logic pwm_slow;
  logic pwm_on;
  modport ctrl (output tick, output duty, output align, output exp_en, output pwm_slow, input pwm_on);
  modport gen (input tick, input duty, input align, input exp_en, input pwm_slow, output pwm_on);
endinterface

/* File: led_pwm_gen.sv */
// 8-bit PWM slot counter, curve mapping and pulse alignment for one LED
`timescale 1ns/1ns
module led_pwm_gen (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Link to engine core
  pwm_if.gen pif
);
  import led_pkg::*;
  `include "led_engine_defs.svh"

  localparam pwm_state_t PWM_RESET = '{slot: 8'h00, div: 1'b0, on: 1'b0};

  pwm_state_t st_r;
  pwm_state_t st_nxt;
  level_t duty_eff;
  logic [8:0] mid_start;
  logic [8:0] slot_w;
  logic [8:0] duty_w;

  // Piecewise exponential: mantissa shifted by the top three bits
  function automatic level_t exp_curve(level_t x);
    logic [12:0] t;
    t = 13'({1'b1, x[4:0]}) << x[7:5];
    if (x == 8'h00) begin
      return 8'h00;
    end
    if (x == 8'hFF) begin
      return 8'hFF;
    end
    return t[12:5];
  endfunction

  always_comb begin
    st_nxt = st_r;
    duty_eff = pif.exp_en ? exp_curve(pif.duty) : pif.duty;
    slot_w = {1'b0, st_r.slot};
    duty_w = {1'b0, duty_eff};
    mid_start = `PWM_HALF - {2'b00, duty_eff[7:1]};
    // Half rate skips every other oscillator tick
    if (pif.tick) begin
      if (pif.pwm_slow && !st_r.div) begin
        st_nxt.div = 1'b1;
      end else begin
        st_nxt.div = 1'b0;
        st_nxt.slot = st_r.slot + 8'h01;
      end
    end
    unique case (pif.align)
      ALIGN_FORWARD: st_nxt.on = slot_w < duty_w;
      ALIGN_MIDDLE: st_nxt.on = (slot_w >= mid_start) && (slot_w < mid_start + duty_w);
      ALIGN_BACKWARD: st_nxt.on = (slot_w + duty_w) > 9'h0FF;
      default: st_nxt.on = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= PWM_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pif.pwm_on = st_r.on;
endmodule

/* File: led_anim_engine.sv */
// Per-LED current scaling, PWM clocking, sync pin and autonomous animation sequencer
// What this block does
// - One global current range bit, reset 0: 0 gives 25.5 mA, 1 gives 51 mA.
// - Per-LED 8-bit current level, 256 steps, resets to 80h.
// - Sink current equals full scale times level divided by 255.
// - 8-bit PWM at 24 kHz or 12 kHz, picked by one select bit.
// - PWM timing comes from internal 6 MHz oscillator unless sync pin is input.
// - Direction bit: sync pin drives internal clock out, or accepts outside clock.
// - Three pulse alignments: forward, middle-centred, backward.
// - Per-LED curve bit selects exponential or linear duty mapping.
// - Manual mode follows configuration immediately; autonomous mode follows the sequencer.
// - Each LED has its own sequencer: three ramp groups, two hold intervals.
// - After launch the pattern runs alone without further host brightness commands.
// - Current PWM value and unit progress are readable while running.
// - Groups two and three are skipped when their repeat count is 0.
// - Autonomous mode takes current level from separate autonomous level inputs.
// - Pattern and group repeat codes mean zero, one, two, or infinite; group one still plays once at code 0.
// - A group has five levels and four durations, four ramps level one to five.
// - Ramp moves up to 256 steps start to end in its duration, curve supported.
// - 4-bit duration code, 16 levels, 0h zero time to Fh about 8.05 s.
// - Zero-duration ramp is skipped; equal start and end holds constant.
// - Hold intervals use the same duration code; zero skips the hold.
// - First hold shows level one of next group; second shows level five of previous.
`timescale 1ns/1ns
module led_anim_engine #(
  parameter int unsigned TICKS_PER_MS = `TICKS_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Current range and level register writes
  input wire logic range_wr,
  input wire logic range_wdata,
  input wire logic level_wr,
  input wire led_pkg::level_t level_wdata,
  // Dimming configuration
  input wire logic pwm_slow_sel,
  input wire logic sync_dir_out,
  input wire led_pkg::align_t align_sel,
  input wire logic exp_en,
  input wire logic auto_mode,
  input wire led_pkg::level_t manual_pwm,
  input wire led_pkg::level_t auto_current_level,
  // Animation pattern
  input wire led_pkg::dur_code_t hold1_dur,
  input wire led_pkg::dur_code_t hold2_dur,
  input wire logic [1:0] pattern_repeat_count,
  input wire led_pkg::group_cfg_t [2:0] group_cfg,
  // Animation commands
  input wire logic start_cmd,
  input wire logic hold_cmd,
  // Sync pin
  input wire logic sync_in,
  output logic sync_out_r,
  output logic sync_oe_b_r,
  // Drive and readback
  output logic current_range_r,
  output led_pkg::level_t dot_current_level_r,
  output logic [8:0] sink_current_r,
  output logic led_pwm_r,
  output led_pkg::level_t anim_pwm_r,
  output led_pkg::seq_state_t unit_state_r,
  output logic [1:0] group_idx_r,
  output logic [1:0] ramp_idx_r
);
  import led_pkg::*;
  `include "led_engine_defs.svh"

  localparam engine_state_t ST_RESET = '{
    current_range: `CUR_RANGE_RST,
    current_level: `CUR_LEVEL_RST,
    sync_oe_b: 1'b1,
    seq: SEQ_IDLE,
    align: ALIGN_FORWARD,
    default: '0
  };

  engine_state_t st_r;
  engine_state_t st_nxt;
  pwm_if pif ();

  logic [5:0] osc_sum;
  logic osc_wrap;
  logic ext_edge;
  dur_code_t cur_dur;
  logic [31:0] limit;
  logic [31:0] acc_sum;
  logic unit_done;
  logic [1:0] ng;
  group_cfg_t g;

  // Sink current in 0.1 mA units, exact for both ranges
  function automatic logic [8:0] current_tenths(logic range, level_t lvl);
    logic [31:0] fs;
    fs = range ? `FULL_SCALE_HIGH_UA : `FULL_SCALE_LOW_UA;
    return 9'((fs * {24'h000000, lvl}) / (`CODE_FULL * `CURRENT_LSB_UA));
  endfunction

  function automatic logic [13:0] dur_ms(dur_code_t c);
    unique case (c)
      4'h0: return 14'(`DUR_MS_0);
      4'h1: return 14'(`DUR_MS_1);
      4'h2: return 14'(`DUR_MS_2);
      4'h3: return 14'(`DUR_MS_3);
      4'h4: return 14'(`DUR_MS_4);
      4'h5: return 14'(`DUR_MS_5);
      4'h6: return 14'(`DUR_MS_6);
      4'h7: return 14'(`DUR_MS_7);
      4'h8: return 14'(`DUR_MS_8);
      4'h9: return 14'(`DUR_MS_9);
      4'hA: return 14'(`DUR_MS_A);
      4'hB: return 14'(`DUR_MS_B);
      4'hC: return 14'(`DUR_MS_C);
      4'hD: return 14'(`DUR_MS_D);
      4'hE: return 14'(`DUR_MS_E);
      4'hF: return 14'(`DUR_MS_F);
    endcase
  endfunction

  // Linear interpolation; step 256 lands exactly on the end level
  function automatic level_t interp(level_t a, level_t b, logic [8:0] s);
    logic signed [9:0] diff;
    logic signed [19:0] prod;
    logic signed [10:0] res;
    diff = $signed({2'b00, b}) - $signed({2'b00, a});
    prod = 20'(diff * $signed({1'b0, s}));
    res = $signed({3'b000, a}) + 11'(prod >>> 8);
    return res[7:0];
  endfunction

  // Whether a repeat code asks for another play; infinite code is handled here
  function automatic logic more_plays(logic [1:0] code, logic [1:0] done_plays);
    return (code == `REPEAT_INFINITE) || ({1'b0, code} > ({1'b0, done_plays} + 3'h1));
  endfunction

  always_comb begin
    st_nxt = st_r;
    g = group_cfg[st_r.grp];
    ng = `NO_GROUP;
    limit = 32'h00000000;
    acc_sum = 32'h00000000;
    unit_done = 1'b0;
    cur_dur = 4'h0;

    // Register writes
    if (range_wr) begin
      st_nxt.current_range = range_wdata;
    end
    if (level_wr) begin
      st_nxt.current_level = level_wdata;
    end

    // Internal oscillator at 6 MHz on average; edges jitter by one system clock
    osc_sum = {1'b0, st_r.osc_acc} + 6'(`OSC_ACC_INC);
    osc_wrap = osc_sum >= 6'(`OSC_ACC_MOD);
    st_nxt.osc_acc = osc_wrap ? 5'(osc_sum - 6'(`OSC_ACC_MOD)) : osc_sum[4:0];
    if (osc_wrap) begin
      st_nxt.sync_osc = ~st_r.sync_osc;
    end

    // Outside clock passes two flops before edge detection
    st_nxt.sync_meta = sync_in;
    st_nxt.sync_sync = st_r.sync_meta;
    st_nxt.sync_prev = st_r.sync_sync;
    ext_edge = st_r.sync_sync && !st_r.sync_prev;
    st_nxt.sync_oe_b = ~sync_dir_out;
    // A shared sync clock keeps sibling sequencers in step
    st_nxt.tick = sync_dir_out ? (osc_wrap && !st_r.sync_osc) : ext_edge;

    // Unit timer: 256 steps spread over the unit duration in oscillator ticks
    unique case (st_r.seq)
      SEQ_HOLD1: cur_dur = hold1_dur;
      SEQ_HOLD2: cur_dur = hold2_dur;
      SEQ_RAMP: cur_dur = g.dur[st_r.rmp];
      default: cur_dur = 4'h0;
    endcase
    limit = {18'h00000, dur_ms(cur_dur)} * TICKS_PER_MS;
    acc_sum = {6'h00, st_r.time_acc} + `STEP_ADD;
    unit_done = (cur_dur == 4'h0) || (st_r.step == `STEP_END);
    // Hold command freezes the timer so readback is stable
    if (st_r.tick && !hold_cmd && !unit_done && (st_r.seq != SEQ_IDLE) && (st_r.seq != SEQ_DONE)) begin
      if (acc_sum >= limit) begin
        st_nxt.time_acc = 26'(acc_sum - limit);
        st_nxt.step = st_r.step + 9'h001;
      end else begin
        st_nxt.time_acc = acc_sum[25:0];
      end
    end

    // Level shown by the running unit; zero-length units leave it untouched
    unique case (st_r.seq)
      SEQ_HOLD1: begin
        if (cur_dur != 4'h0) begin
          st_nxt.anim_pwm = group_cfg[0].level[0];
        end
      end
      SEQ_HOLD2: begin
        if (cur_dur != 4'h0) begin
          st_nxt.anim_pwm = g.level[4];
        end
      end
      SEQ_RAMP: begin
        if (cur_dur != 4'h0) begin
          st_nxt.anim_pwm = interp(g.level[st_r.rmp], g.level[3'({1'b0, st_r.rmp} + 3'h1)], st_r.step);
        end
      end
      default: begin
      end
    endcase

    // Sequencer advance
    if (unit_done) begin
      st_nxt.time_acc = 26'h0000000;
      st_nxt.step = 9'h000;
      unique case (st_r.seq)
        SEQ_HOLD1: begin
          st_nxt.seq = SEQ_RAMP;
          st_nxt.grp = 2'h0;
          st_nxt.rmp = 2'h0;
          st_nxt.grp_plays = 2'h0;
        end
        SEQ_RAMP: begin
          if (st_r.rmp != `LAST_RAMP) begin
            st_nxt.rmp = st_r.rmp + 2'h1;
          end else if (more_plays(g.group_repeat_count, st_r.grp_plays)) begin
            st_nxt.rmp = 2'h0;
            st_nxt.grp_plays = st_r.grp_plays + 2'h1;
          end else begin
            // Groups two and three with a zero repeat count are never entered
            if (st_r.grp == 2'h0 && group_cfg[1].group_repeat_count != `REPEAT_NONE) begin
              ng = 2'h1;
            end else if (st_r.grp != 2'h2 && group_cfg[2].group_repeat_count != `REPEAT_NONE) begin
              ng = 2'h2;
            end
            if (ng == `NO_GROUP) begin
              st_nxt.seq = SEQ_HOLD2;
            end else begin
              st_nxt.grp = ng;
              st_nxt.rmp = 2'h0;
              st_nxt.grp_plays = 2'h0;
            end
          end
        end
        SEQ_HOLD2: begin
          if (more_plays(pattern_repeat_count, st_r.pat_plays)) begin
            st_nxt.pat_plays = st_r.pat_plays + 2'h1;
            st_nxt.seq = SEQ_HOLD1;
          end else begin
            st_nxt.seq = SEQ_DONE;
          end
        end
        default: begin
        end
      endcase
    end

    // Launch and leave; the pattern then runs with no host help
    if (!auto_mode) begin
      st_nxt.seq = SEQ_IDLE;
    end else if (start_cmd) begin
      st_nxt.seq = (pattern_repeat_count == `REPEAT_NONE) ? SEQ_DONE : SEQ_HOLD1;
      st_nxt.grp = 2'h0;
      st_nxt.rmp = 2'h0;
      st_nxt.grp_plays = 2'h0;
      st_nxt.pat_plays = 2'h0;
      st_nxt.time_acc = 26'h0000000;
      st_nxt.step = 9'h000;
    end

    // Drive source selection
    if (auto_mode) begin
      st_nxt.sink_current = current_tenths(st_r.current_range, auto_current_level);
      st_nxt.duty = st_r.anim_pwm;
    end else begin
      st_nxt.sink_current = current_tenths(st_r.current_range, st_r.current_level);
      st_nxt.duty = manual_pwm;
    end
    st_nxt.align = align_sel;
    st_nxt.exp_en = exp_en;
    st_nxt.pwm_slow = pwm_slow_sel;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pif.tick = st_r.tick;
  assign pif.duty = st_r.duty;
  assign pif.align = st_r.align;
  assign pif.exp_en = st_r.exp_en;
  assign pif.pwm_slow = st_r.pwm_slow;

  led_pwm_gen u_pwm (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pif(pif.gen)
  );

  // Readback straight from state flops
  assign sync_out_r = st_r.sync_osc;
  assign sync_oe_b_r = st_r.sync_oe_b;
  assign current_range_r = st_r.current_range;
  assign dot_current_level_r = st_r.current_level;
  assign sink_current_r = st_r.sink_current;
  assign led_pwm_r = pif.pwm_on;
  assign anim_pwm_r = st_r.anim_pwm;
  assign unit_state_r = st_r.seq;
  assign group_idx_r = st_r.grp;
  assign ramp_idx_r = st_r.rmp;
endmodule

/* File: led_engine_properties.sv */
// Port-level checks for the LED dimming and animation engine
`timescale 1ns/1ns
module led_engine_checker
#(
  parameter int unsigned TICKS_PER_MS = 6000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Watched inputs
  input wire logic range_wr,
  input wire logic range_wdata,
  input wire logic level_wr,
  input wire led_pkg::level_t level_wdata,
  input wire logic sync_dir_out,
  input wire led_pkg::align_t align_sel,
  input wire logic auto_mode,
  input wire led_pkg::level_t manual_pwm,
  input wire logic [1:0] pattern_repeat_count,
  input wire led_pkg::group_cfg_t [2:0] group_cfg,
  input wire logic start_cmd,
  // Watched outputs
  input wire logic sync_out_r,
  input wire logic sync_oe_b_r,
  input wire logic current_range_r,
  input wire led_pkg::level_t dot_current_level_r,
  input wire logic [8:0] sink_current_r,
  input wire logic led_pwm_r,
  input wire led_pkg::level_t anim_pwm_r,
  input wire led_pkg::seq_state_t unit_state_r
);
  import led_pkg::*;
  logic last_r;
  logic [2:0] still_r;
  // Samples since the sync output last changed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      last_r <= 1'b0;
      still_r <= 3'h0;
    end else begin
      last_r <= sync_out_r;
      still_r <= (sync_out_r != last_r) ? 3'h0 : still_r + 3'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_range_store:
    assert property (range_wr |=> current_range_r == $past(range_wdata))
    else $error("range bit not taken from write");
  a_level_store:
    assert property (level_wr |=> dot_current_level_r == $past(level_wdata))
    else $error("current level not taken from write");
  a_sink_scale:
    assert property ($past(rst_b) && !auto_mode && !$past(auto_mode) && !$past(auto_mode, 2) |->
      sink_current_r == ($past(current_range_r) ? {$past(dot_current_level_r), 1'b0}
      : {1'b0, $past(dot_current_level_r)}))
    else $error("sink current not scaled from level");
  a_oe_follows:
    assert property ($past(rst_b) |-> sync_oe_b_r == !$past(sync_dir_out))
    else $error("sync pin direction wrong");
  a_sync_toggles:
    assert property (still_r <= 3'h3)
    else $error("internal sync clock stalled");
  a_start_answer:
    assert property (start_cmd && auto_mode |=>
      unit_state_r == (($past(pattern_repeat_count) == 2'h0) ? SEQ_DONE : SEQ_HOLD1))
    else $error("launch not answered");
  a_manual_idle:
    assert property (!auto_mode |=> unit_state_r == SEQ_IDLE)
    else $error("sequencer active in manual mode");
  a_hold1_shows:
    assert property (unit_state_r == SEQ_HOLD1 && $past(unit_state_r) == SEQ_HOLD1 |->
      anim_pwm_r == group_cfg[0].level[0])
    else $error("first hold shows wrong level");
  a_dark_align:
    assert property (align_sel == 2'h3 && $past(align_sel) == 2'h3 && $past(align_sel, 2) == 2'h3 |-> !led_pwm_r)
    else $error("pulse with unused alignment");
  a_zero_dark:
    assert property (!$past(auto_mode, 2) && $past(manual_pwm, 2) == 8'h00 |-> !led_pwm_r)
    else $error("pulse with zero duty");
endmodule
bind led_anim_engine led_engine_checker #(.TICKS_PER_MS(TICKS_PER_MS)) u_chk (
  .sys_clk, .rst_b, .range_wr, .range_wdata, .level_wr, .level_wdata, .sync_dir_out, .align_sel, .auto_mode,
  .manual_pwm, .pattern_repeat_count, .group_cfg, .start_cmd, .sync_out_r, .sync_oe_b_r, .current_range_r,
  .dot_current_level_r, .sink_current_r, .led_pwm_r, .anim_pwm_r, .unit_state_r
);

/* File: led_sync_peer.sv */
// Sibling driver sharing the sync pin clock
`timescale 1ns/1ns
module led_sync_peer #(
  parameter int HALF_NS = 80
) (
  // Bench control
  input wire logic drive,
  input wire logic run,
  // Device side of the shared pin
  input wire logic sync_out_r,
  input wire logic sync_oe_b_r,
  output logic sync_wire
);
  logic clk_r = 1'b0;
  logic idle_r = 1'b0;
  // Clock only while owning the pin and running
  always begin
    #(HALF_NS);
    if (drive && run) clk_r = !clk_r;
    idle_r = !idle_r;
  end
  // A pin driven by neither side toggles; a driving peer that is not running holds its level
  always_comb begin
    if (!sync_oe_b_r) sync_wire = sync_out_r;
    else if (drive) sync_wire = clk_r;
    else sync_wire = idle_r;
  end
endmodule

/* File: led_anim_engine_bench.sv */
// Self-checking bench for the LED dimming and animation engine
`timescale 1ns/1ns
module led_anim_engine_bench;
  import led_pkg::*;
  logic sys_clk, rst_b, range_wr, range_wdata, level_wr, pwm_slow_sel, sync_dir_out, exp_en, auto_mode;
  logic start_cmd, hold_cmd, sync_in, sync_out_r, sync_oe_b_r, current_range_r, led_pwm_r, peer_drive, peer_run;
  level_t level_wdata, manual_pwm, auto_current_level, dot_current_level_r, anim_pwm_r;
  align_t align_sel;
  dur_code_t hold1_dur, hold2_dur;
  logic [1:0] pattern_repeat_count, group_idx_r, ramp_idx_r;
  group_cfg_t [2:0] group_cfg;
  logic [8:0] sink_current_r;
  seq_state_t unit_state_r;
  int n_fail = 0, checked = 0, seed = 20109, cycles = 0;
  // Below 3 ticks per ms the shortest codes would be stretched to 256 ticks
  localparam int TPM = 3;
  led_anim_engine #(.TICKS_PER_MS(TPM)) dut (.sys_clk, .rst_b, .range_wr, .range_wdata, .level_wr, .level_wdata,
    .pwm_slow_sel, .sync_dir_out, .align_sel, .exp_en, .auto_mode, .manual_pwm, .auto_current_level, .hold1_dur,
    .hold2_dur, .pattern_repeat_count, .group_cfg, .start_cmd, .hold_cmd, .sync_in, .sync_out_r, .sync_oe_b_r,
    .current_range_r, .dot_current_level_r, .sink_current_r, .led_pwm_r, .anim_pwm_r, .unit_state_r,
    .group_idx_r, .ramp_idx_r);
  led_sync_peer peer (.drive(peer_drive), .run(peer_run), .sync_out_r, .sync_oe_b_r, .sync_wire(sync_in));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = !sys_clk;
  end
  task automatic close_out;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Expected run is about 45k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_near(input int got, input int exp, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] exp_sink(input logic rng, input level_t lvl);
    return rng ? {lvl, 1'b0} : {1'b0, lvl};
  endfunction
  function automatic int exp_on(input level_t x, input logic e);
    if (!e || x == 8'h00 || x == 8'hFF) return int'(x);
    return (int'({1'b1, x[4:0]}) << x[7:5]) >> 5;
  endfunction
  function automatic int dur_ms(input int c);
    int t[16] = '{0, 90, 180, 360, 540, 800, 1070, 1520, 2060, 2500, 3040, 4020, 5010, 5990, 7060, 8050};
    return t[c];
  endfunction
  task automatic launch;
    start_cmd = 1'b1;
    @(negedge sys_clk);
    start_cmd = 1'b0;
  endtask
  task automatic duty_count(input int win, output int hi, output int rises);
    logic prev;
    hi = 0;
    rises = 0;
    prev = led_pwm_r;
    repeat (win) begin
      @(negedge sys_clk);
      hi += (led_pwm_r === 1'b1) ? 1 : (led_pwm_r === 1'b0) ? 0 : 99999;
      rises += int'(led_pwm_r && !prev);
      prev = led_pwm_r;
    end
  endtask
  // Zero-duration walk: one entry per cycle
  task automatic build(ref logic [8:0] q[$]);
    int plays;
    q.delete();
    for (int p = 0; p < int'(pattern_repeat_count); p++) begin
      q.push_back({SEQ_HOLD1, 4'h0});
      for (int g = 0; g < 3; g++) begin
        plays = (g == 0 && group_cfg[0].group_repeat_count == 2'h0) ? 1 : int'(group_cfg[g].group_repeat_count);
        repeat (plays) for (int r = 0; r < 4; r++) q.push_back({SEQ_RAMP, 2'(g), 2'(r)});
      end
      q.push_back({SEQ_HOLD2, 4'h0});
    end
    q.push_back({SEQ_DONE, 4'h0});
  endtask
  initial begin
    int hi, n;
    level_t d;
    logic [8:0] q[$];
    {rst_b, range_wr, range_wdata, level_wr, pwm_slow_sel, exp_en, auto_mode, start_cmd, hold_cmd} = '0;
    {peer_drive, peer_run, level_wdata, manual_pwm, auto_current_level, hold1_dur, hold2_dur} = '0;
    pattern_repeat_count = 2'h0;
    group_cfg = '0;
    align_sel = ALIGN_FORWARD;
    sync_dir_out = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(current_range_r, 1'b0);
    check(dot_current_level_r, 8'h80);
    check(unit_state_r, SEQ_IDLE);
    rst_b = 1'b1;
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      range_wdata = 1'($random(seed));
      level_wdata = d;
      {range_wr, level_wr} = 2'h3;
      @(negedge sys_clk);
      {range_wr, level_wr} = 2'h0;
      check(current_range_r, range_wdata);
      check(dot_current_level_r, d);
      @(negedge sys_clk);
      check(sink_current_r, exp_sink(range_wdata, d));
    end
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed)) | 8'h01;
      manual_pwm = d;
      align_sel = align_t'(2'((k < 4) ? k : 0));
      exp_en = (k == 4);
      pwm_slow_sel = (k == 5);
      repeat (4) @(negedge sys_clk);
      duty_count(4267, hi, n);
      check_near(hi, (k == 3) ? 0 : exp_on(d, exp_en) * 4267 / 256, 12);
      check_near(2 * n, (k == 3) ? 0 : (k == 5) ? 5 : 9, 1);
    end
    {exp_en, pwm_slow_sel, sync_dir_out, peer_drive} = 4'h1;
    align_sel = ALIGN_FORWARD;
    manual_pwm = 8'h40;
    repeat (8) @(negedge sys_clk);
    duty_count(1500, hi, n);
    check(n, 0);
    peer_run = 1'b1;
    repeat (8) @(negedge sys_clk);
    duty_count(4096, hi, n);
    check_near(hi, 64 * 16, 12);
    {sync_dir_out, peer_drive, peer_run} = 3'h4;
    auto_mode = 1'b1;
    auto_current_level = 8'($random(seed));
    repeat (4) @(negedge sys_clk);
    check(sink_current_r, exp_sink(range_wdata, auto_current_level));
    for (int k = 0; k < 6; k++) begin
      pattern_repeat_count = 2'($unsigned($random(seed)) % 3);
      for (int g = 0; g < 3; g++) begin
        group_cfg[g].group_repeat_count = 2'($unsigned($random(seed)) % 3);
        // Skipped ramps share one random level, so a stray update shows
        group_cfg[g].level = {5{8'($random(seed))}};
      end
      build(q);
      launch();
      foreach (q[i]) begin
        check({unit_state_r, (unit_state_r == SEQ_RAMP) ? {group_idx_r, ramp_idx_r} : 4'h0}, q[i]);
        @(negedge sys_clk);
      end
    end
    check(anim_pwm_r, 8'h00);
    pattern_repeat_count = 2'h3;
    launch();
    repeat (300) @(negedge sys_clk);
    check(unit_state_r == SEQ_DONE, 1'b0);
    // Endless group one inside a single pattern play
    group_cfg[0].group_repeat_count = 2'h3;
    pattern_repeat_count = 2'h1;
    launch();
    repeat (300) @(negedge sys_clk);
    check({unit_state_r, group_idx_r}, {SEQ_RAMP, 2'h0});
    for (int c = 1; c < 4; c++) begin
      group_cfg = '0;
      group_cfg[0].level = {$random(seed), 8'($random(seed))};
      group_cfg[0].dur[0] = 4'h1;
      hold1_dur = 4'(c);
      hold2_dur = (c == 2) ? 4'h1 : 4'h0;
      pattern_repeat_count = 2'h1;
      launch();
      n = 0;
      while (unit_state_r == SEQ_HOLD1 && n < 9000) begin
        hold_cmd = (c == 3 && n >= 100 && n < 400);
        n++;
        @(negedge sys_clk);
      end
      check_near(n, dur_ms(c) * TPM * 25 / 6 + ((c == 3) ? 300 : 0), 10);
      n = 0;
      while (unit_state_r != SEQ_DONE && n < 3000) begin
        n++;
        @(negedge sys_clk);
      end
      check(anim_pwm_r, group_cfg[0].level[(c == 2) ? 4 : 1]);
    end
    auto_mode = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(unit_state_r, SEQ_IDLE);
    close_out();
  end
endmodule
